/* File: dv/sorr_assertions.sv */
// Purpose: Port checks for the option register bank.
// Assumes: Zero-wait APB, one-cycle pulses, synchronous reset.
// Notes: Sees only top-level ports.
`timescale 1ns/10ps
module sorr_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sorr_pkg::SORR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_request,
  input wire logic stop_entry,
  input wire logic illegal_opcode_reset,
  input wire logic serial_transmit_line,
  input wire logic serial_transmit_pin,
  input wire logic pwm_sync_trigger,
  input wire logic converter_trigger
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_err_unaligned: assert property (psel && !penable && paddr[1:0] != 2'h0
    |=> pslverr && pready) else $error("unaligned access not refused");
  a_rsvd_read_zero: assert property (pready && !pwrite && paddr == 12'h014
    |-> prdata[31:8] == 24'h0 && !prdata[6] && prdata[3:2] == 2'h0)
    else $error("reserved bits not zero");
  a_sync_on_write: assert property (psel && penable && pready && pwrite && !pslverr
    && paddr == 12'h014 && pwdata[6] |=> pwm_sync_trigger)
    else $error("sync pulse missing");
  a_sync_has_cause: assert property (pwm_sync_trigger
    |-> $past(pwrite && pready && !pslverr && paddr == 12'h014 && pwdata[6]))
    else $error("sync pulse without write");
  a_stop_one_answer: assert property (stop_request
    |=> stop_entry != illegal_opcode_reset)
    else $error("stop request not answered once");
  a_stop_has_cause: assert property (stop_entry || illegal_opcode_reset
    |-> $past(stop_request))
    else $error("stop answer without request");
  a_tx_gated: assert property (!$past(rst) && serial_transmit_pin
    |-> $past(serial_transmit_line))
    else $error("transmit pin high without transmit data");
  a_trig_single: assert property (converter_trigger |=> !converter_trigger)
    else $error("converter trigger longer than one cycle");
endmodule

bind sorr_regs sorr_assertions sorr_assertions_inst (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stop_request(stop_request),
  .stop_entry(stop_entry), .illegal_opcode_reset(illegal_opcode_reset),
  .serial_transmit_line(serial_transmit_line),
  .serial_transmit_pin(serial_transmit_pin), .pwm_sync_trigger(pwm_sync_trigger),
  .converter_trigger(converter_trigger));

/* File: dv/sorr_far_model.sv */
// Purpose: Timer side that raises trigger levels on command.
// Assumes: fire is a one-cycle request on clk.
// Notes: Level is held six cycles so only its rising edge may count.
`timescale 1ns/10ps
module sorr_far_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [1:0] src,
  output sorr_pkg::sorr_trig_t trig
);
  logic [2:0] hold_q = 3'h0;
  logic [3:0] lvl;

  always @(posedge clk) begin
    if (fire) begin
      hold_q <= 3'h6;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end

  always_comb begin
    lvl = 4'h0;
    lvl[src] = (hold_q != 3'h0);
    trig = sorr_pkg::sorr_trig_t'(lvl);
  end
endmodule

/* File: dv/sorr_regs_test.sv */
// Purpose: Self-checking bench for the option register bank.
// Assumes: Zero-wait APB slave, 40 MHz clock.
// Notes: Expected values are built from the register layout only.
`timescale 1ns/10ps
module sorr_regs_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic pready, pslverr, stop_request = 1'b0, stop_entry, ill, fwe;
  logic tx = 1'b0, ch0 = 1'b0, pin, rx = 1'b1, comp = 1'b0, srx, cap, sync, conv;
  logic fire = 1'b0;
  logic [1:0] src = 2'h0;
  sorr_pkg::sorr_trig_t trig;
  integer seed = 32'h2240;
  int error_cnt = 0, tests_run = 0, cyc = 0, n;

  always #12.5 clk = ~clk;

  sorr_regs sorr_regs_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_request(stop_request), .stop_entry(stop_entry),
    .illegal_opcode_reset(ill), .fast_wakeup_enable(fwe), .serial_transmit_line(tx),
    .pwm_timer_0_ch0(ch0), .serial_transmit_pin(pin), .serial_receive_line(rx),
    .analog_comparator_out(comp), .serial_port_0_rx(srx), .pwm_timer_0_ch1_capture(cap),
    .pwm_sync_trigger(sync), .trig_in(trig), .converter_trigger(conv));
  sorr_far_model sorr_far_model_inst (.clk(clk), .fire(fire), .src(src), .trig(trig));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Idle cycle before each setup, so no drive is assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  task automatic stop(input logic permit);
    @(posedge clk);
    stop_request <= 1'b1;
    @(posedge clk);
    stop_request <= 1'b0;
    #1;
    chk({31'h0, stop_entry}, {31'h0, permit});
    chk({31'h0, ill}, {31'h0, !permit});
  endtask

  task automatic trig_run(input logic [1:0] s, input logic [7:0] m, input logic [2:0] p,
                          output int cnt);
    int extra;
    extra = 0;
    wr(12'h01C, {24'h0, m});
    wr(12'h018, {29'h0, p});
    wr(12'h014, {30'h0, s});
    @(posedge clk);
    fire <= 1'b1;
    src <= s;
    @(posedge clk);
    fire <= 1'b0;
    cnt = 0;
    while (cnt < 2000) begin
      @(posedge clk);
      cnt++;
      #1;
      if (conv === 1'b1) break;
    end
    repeat (8) begin
      @(posedge clk);
      #1;
      if (conv === 1'b1) extra++;
    end
    chk(32'(extra), 32'h0);
  endtask

  task final_report;
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(12'h010, 32'h0, 1'b0);
    rd(12'h014, 32'h0, 1'b0);
    rd(12'h018, 32'h0, 1'b0);
    rd(12'h01C, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    rd(12'h015, 32'h0, 1'b1);
    wr(12'h014, 32'h0);
    stop(1'b0);
    wr(12'h010, 32'h3);
    #1;
    chk({31'h0, fwe}, 32'h1);
    stop(1'b1);
    // No wake events in the nine cycles after a permitted stop
    repeat (9) @(posedge clk);
    wr(12'h010, 32'h0);
    rd(12'h010, 32'h3, 1'b0);
    chk({31'h0, fwe}, 32'h1);
    // Random routing settings with random line levels
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      v = $random(seed);
      tx <= v[8];
      ch0 <= v[9];
      rx <= v[10];
      comp <= v[11];
      wr(12'h014, {24'h0, v[7:0]});
      rd(12'h014, {24'h0, v[7:0] & 8'hB3}, 1'b0);
      repeat (8) @(posedge clk);
      #1;
      chk({31'h0, pin}, {31'h0, v[8] & (v[7] ? v[9] : 1'b1)});
      chk({31'h0, srx}, {31'h0, v[5] ? v[11] : v[10]});
      chk({31'h0, cap}, {31'h0, v[4] ? (v[5] ? v[11] : v[10]) : 1'b1});
    end
    wr(12'h014, 32'h40);
    #1;
    chk({31'h0, sync}, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, sync}, 32'h0);
    for (int s = 0; s < 4; s++) begin
      v = $random(seed) & 32'h7;
      trig_run(s[1:0], v[7:0], 3'h0, n);
      chk(32'(n), (s < 2) ? 32'h1 : 32'h3 + v);
    end
    // Slow prescaler: flag must read set while the count runs
    fork
      trig_run(2'h3, 8'h14, 3'h2, n);
      begin
        repeat (30) @(posedge clk);
        rd(12'h018, 32'h82, 1'b0);
      end
    join
    chk(32'(n >= 83 && n <= 87), 32'h1);
    rd(12'h018, 32'h02, 1'b0);
    rd(12'h01C, 32'h14, 1'b0);
    final_report;
  end
endmodule

/* File: verilog/sorr_pkg.sv */
// Purpose: Shared constants and carriers for the system option routing register bank.
// Assumes: 32-bit APB data, registers in the low byte of aligned words.
// Notes: Register indices are multiplied by four to give the byte address.
package sorr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int SORR_ADDR_W = 12;
  localparam int SORR_IDX_W = 10;
  localparam logic [SORR_IDX_W-1:0] SORR_IDX_OPT1 = 10'h004;
  localparam logic [SORR_IDX_W-1:0] SORR_IDX_OPT2 = 10'h005;
  localparam logic [SORR_IDX_W-1:0] SORR_IDX_OPT3 = 10'h006;
  localparam logic [SORR_IDX_W-1:0] SORR_IDX_DELAY = 10'h007;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SORR_OPT1_FAST_WAKE_BIT = 1;
  localparam int SORR_OPT1_STOP_BIT = 0;
  localparam int SORR_OPT2_TXMOD_BIT = 7;
  localparam int SORR_OPT2_SYNC_BIT = 6;
  localparam int SORR_OPT2_RXFILT_BIT = 5;
  localparam int SORR_OPT2_RXCAP_BIT = 4;
  localparam int SORR_OPT3_DELAY_BUSY_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic SORR_RST_FAST_WAKE = 1'h0;
  localparam logic SORR_RST_STOP = 1'h0;
  localparam logic [7:0] SORR_RST_OPT2 = 8'h00;
  localparam logic [2:0] SORR_RST_PRESCALE = 3'h0;
  localparam logic [7:0] SORR_RST_DELAY = 8'h00;

  // ----------------------------------------------------------------
  // Converter trigger source encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SORR_SRC_RTC = 2'h0;
  localparam logic [1:0] SORR_SRC_MTIM = 2'h1;
  localparam logic [1:0] SORR_SRC_T2_INIT = 2'h2;
  localparam logic [1:0] SORR_SRC_T2_MATCH = 2'h3;

  // Second option register layout
  typedef struct packed {
    logic transmit_modulation_select;
    logic pwm_sync_trigger;
    logic receive_filter_select;
    logic receive_capture_select;
    logic [1:0] reserved;
    logic [1:0] converter_trigger_source;
  } sorr_opt2_t;

  // Trigger inputs, one bit per source in encoding order
  typedef struct packed {
    logic t2_match;
    logic t2_init;
    logic mtim_overflow;
    logic rtc_overflow;
  } sorr_trig_t;

endpackage

/* File: verilog/sorr_regs.sv */
// Purpose: System option register bank steering wake, stop, serial routing and
//          converter triggering, reached over APB.
// Assumes: All trigger, stop and serial transmit inputs are on clk; the receive pin
//          and comparator output are asynchronous.
// Notes: Zero wait states after the setup cycle; registers sit in the low byte.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps

module sorr_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sorr_pkg::SORR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_request,
  output logic stop_entry,
  output logic illegal_opcode_reset,
  output logic fast_wakeup_enable,
  input wire logic serial_transmit_line,
  input wire logic pwm_timer_0_ch0,
  output logic serial_transmit_pin,
  input wire logic serial_receive_line,
  input wire logic analog_comparator_out,
  output logic serial_port_0_rx,
  output logic pwm_timer_0_ch1_capture,
  output logic pwm_sync_trigger,
  input wire sorr_pkg::sorr_trig_t trig_in,
  output logic converter_trigger
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic fast_wake_q, fast_wake_d;
  logic stop_q, stop_d;
  logic opt1_lock_q, opt1_lock_d;
  sorr_pkg::sorr_opt2_t opt2_q, opt2_d;
  logic [2:0] prescale_q, prescale_d;
  logic [7:0] delay_mod_q, delay_mod_d;
  logic sync_q, sync_d;

  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic setup;
  logic wr_en;
  logic hit;
  logic [7:0] rd_byte;
  logic [sorr_pkg::SORR_IDX_W-1:0] idx;

  logic stop_entry_q, stop_entry_d;
  logic illegal_q, illegal_d;

  logic rx_sync;
  logic cmp_sync;
  logic txd_q, txd_d;
  logic sci_rx_q, sci_rx_d;
  logic cap_q, cap_d;

  sorr_pkg::sorr_trig_t trig_prev_q;
  logic [3:0] rising;
  logic sel_rise;
  logic delay_start;
  logic delay_active;
  logic delay_done;
  logic conv_q, conv_d;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read data and the error flag are formed in the setup cycle, so the
  // access phase completes on its first edge. A status bit that changes
  // during that one cycle is reported as it stood at setup.
  assign idx = paddr[sorr_pkg::SORR_ADDR_W-1:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

  always_comb begin
    hit = (paddr[1:0] == 2'h0);
    rd_byte = 8'h00;
    case (idx)
      sorr_pkg::SORR_IDX_OPT1: begin
        rd_byte[sorr_pkg::SORR_OPT1_FAST_WAKE_BIT] = fast_wake_q;
        rd_byte[sorr_pkg::SORR_OPT1_STOP_BIT] = stop_q;
      end
      sorr_pkg::SORR_IDX_OPT2: begin
        rd_byte = opt2_q;
        rd_byte[sorr_pkg::SORR_OPT2_SYNC_BIT] = 1'h0;
        rd_byte[3:2] = 2'h0;
      end
      sorr_pkg::SORR_IDX_OPT3: begin
        rd_byte[sorr_pkg::SORR_OPT3_DELAY_BUSY_BIT] = delay_active;
        rd_byte[2:0] = prescale_q;
      end
      sorr_pkg::SORR_IDX_DELAY: begin
        rd_byte = delay_mod_q;
      end
      default: begin
        hit = 1'h0;
      end
    endcase
  end

  always_comb begin
    pready_d = setup;
    pslverr_d = pslverr_q;
    prdata_d = prdata_q;
    if (setup) begin
      pslverr_d = !hit;
      prdata_d = {24'h000000, rd_byte};
    end else if (!psel) begin
      pslverr_d = 1'h0;
      prdata_d = 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Option registers
  // ----------------------------------------------------------------
  // The whole first register locks on its first write, so software must
  // set both write-once bits in the same access.
  always_comb begin
    fast_wake_d = fast_wake_q;
    stop_d = stop_q;
    opt1_lock_d = opt1_lock_q;
    opt2_d = opt2_q;
    prescale_d = prescale_q;
    delay_mod_d = delay_mod_q;
    sync_d = 1'h0;
    if (wr_en) begin
      case (idx)
        sorr_pkg::SORR_IDX_OPT1: begin
          if (!opt1_lock_q) begin
            fast_wake_d = pwdata[sorr_pkg::SORR_OPT1_FAST_WAKE_BIT];
            stop_d = pwdata[sorr_pkg::SORR_OPT1_STOP_BIT];
            opt1_lock_d = 1'h1;
          end
        end
        sorr_pkg::SORR_IDX_OPT2: begin
          opt2_d = pwdata[7:0];
          opt2_d.pwm_sync_trigger = 1'h0;
          opt2_d.reserved = 2'h0;
          sync_d = pwdata[sorr_pkg::SORR_OPT2_SYNC_BIT];
        end
        sorr_pkg::SORR_IDX_OPT3: begin
          prescale_d = pwdata[2:0];
        end
        sorr_pkg::SORR_IDX_DELAY: begin
          delay_mod_d = pwdata[7:0];
        end
        default: begin
          opt1_lock_d = opt1_lock_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fast_wake_q <= sorr_pkg::SORR_RST_FAST_WAKE;
      stop_q <= sorr_pkg::SORR_RST_STOP;
      opt1_lock_q <= 1'h0;
      opt2_q <= sorr_pkg::SORR_RST_OPT2;
      prescale_q <= sorr_pkg::SORR_RST_PRESCALE;
      delay_mod_q <= sorr_pkg::SORR_RST_DELAY;
      sync_q <= 1'h0;
    end else begin
      fast_wake_q <= fast_wake_d;
      stop_q <= stop_d;
      opt1_lock_q <= opt1_lock_d;
      opt2_q <= opt2_d;
      prescale_q <= prescale_d;
      delay_mod_q <= delay_mod_d;
      sync_q <= sync_d;
    end
  end

  // ----------------------------------------------------------------
  // Stop and wake control
  // ----------------------------------------------------------------
  // The core uses fast_wakeup_enable to skip vector fetch and resume at
  // the next instruction; interrupt timing after stop is software's duty.
  always_comb begin
    stop_entry_d = stop_request && stop_q;
    illegal_d = stop_request && !stop_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stop_entry_q <= 1'h0;
      illegal_q <= 1'h0;
    end else begin
      stop_entry_q <= stop_entry_d;
      illegal_q <= illegal_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial routing
  // ----------------------------------------------------------------
  sorr_sync u_rx_sync (
    .clk(clk),
    .rst(rst),
    .async_in(serial_receive_line),
    .sync_out(rx_sync)
  );

  sorr_sync u_cmp_sync (
    .clk(clk),
    .rst(rst),
    .async_in(analog_comparator_out),
    .sync_out(cmp_sync)
  );

  // Capture line idles high when not routed, matching an idle serial line
  always_comb begin
    txd_d = serial_transmit_line;
    if (opt2_q.transmit_modulation_select) begin
      txd_d = serial_transmit_line & pwm_timer_0_ch0;
    end
    sci_rx_d = opt2_q.receive_filter_select ? cmp_sync : rx_sync;
    cap_d = opt2_q.receive_capture_select ? sci_rx_d : 1'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txd_q <= 1'h1;
      sci_rx_q <= 1'h1;
      cap_q <= 1'h1;
    end else begin
      txd_q <= txd_d;
      sci_rx_q <= sci_rx_d;
      cap_q <= cap_d;
    end
  end

  // ----------------------------------------------------------------
  // Converter trigger
  // ----------------------------------------------------------------
  // Edges are kept per source so that changing the selection never
  // manufactures an edge from a source that was already high.
  always_comb begin
    rising = trig_in & ~trig_prev_q;
    sel_rise = rising[opt2_q.converter_trigger_source];
    delay_start = 1'h0;
    conv_d = 1'h0;
    case (opt2_q.converter_trigger_source)
      sorr_pkg::SORR_SRC_RTC: begin
        conv_d = sel_rise;
      end
      sorr_pkg::SORR_SRC_MTIM: begin
        conv_d = sel_rise;
      end
      sorr_pkg::SORR_SRC_T2_INIT: begin
        delay_start = sel_rise;
      end
      sorr_pkg::SORR_SRC_T2_MATCH: begin
        delay_start = sel_rise;
      end
      default: begin
        conv_d = 1'h0;
      end
    endcase
    if (delay_done) begin
      conv_d = 1'h1;
    end
  end

  sorr_trig_delay u_delay (
    .clk(clk),
    .rst(rst),
    .start(delay_start),
    .modulo(delay_mod_q),
    .prescale(prescale_q),
    .active(delay_active),
    .done(delay_done)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_prev_q <= 4'h0;
      conv_q <= 1'h0;
    end else begin
      trig_prev_q <= trig_in;
      conv_q <= conv_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign stop_entry = stop_entry_q;
  assign illegal_opcode_reset = illegal_q;
  assign fast_wakeup_enable = fast_wake_q;
  assign serial_transmit_pin = txd_q;
  assign serial_port_0_rx = sci_rx_q;
  assign pwm_timer_0_ch1_capture = cap_q;
  assign pwm_sync_trigger = sync_q;
  assign converter_trigger = conv_q;

endmodule

/* File: verilog/sorr_sync.sv */
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk.
// Notes: Output follows only when the second and third stages agree.
`timescale 1ns/10ps
module sorr_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic s1_q, s2_q, s3_q, out_q;
  logic out_d;

  always_comb begin
    out_d = out_q;
    if (s2_q == s3_q) begin
      out_d = s3_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'h1;
      s2_q <= 1'h1;
      s3_q <= 1'h1;
      out_q <= 1'h1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule

/* File: verilog/sorr_trig_delay.sv */
// Purpose: One-shot trigger delay counter with power-of-two prescaler.
// Assumes: start is a one-cycle pulse on clk.
// Notes: A start while the delay runs is ignored.
`timescale 1ns/10ps
module sorr_trig_delay (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] modulo,
  input wire logic [2:0] prescale,
  output logic active,
  output logic done
);

  logic [6:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;
  logic act_q, act_d;
  logic done_q, done_d;
  logic [6:0] mask;
  logic tick;

  always_comb begin
    mask = 7'((8'h01 << prescale) - 8'h01);
    tick = ((pre_q & mask) == mask);
    pre_d = pre_q + 7'h01;
    cnt_d = cnt_q;
    act_d = act_q;
    done_d = 1'h0;
    if (act_q) begin
      if (cnt_q == modulo) begin
        act_d = 1'h0;
        done_d = 1'h1;
      end else if (tick) begin
        cnt_d = cnt_q + 8'h01;
      end
    end else if (start) begin
      act_d = 1'h1;
      cnt_d = 8'h00;
      pre_d = 7'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= 7'h00;
      cnt_q <= 8'h00;
      act_q <= 1'h0;
      done_q <= 1'h0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      act_q <= act_d;
      done_q <= done_d;
    end
  end

  assign active = act_q;
  assign done = done_q;

endmodule
